/* File: urdr_rx.sv */
/*
 * Receive data recovery for an asynchronous serial line, with its
 * registers on an AXI4-Lite slave.
 * Assumes rx_i is already synchronous to sys_clk_i and that the far
 * transmitter sends LSB first at the nominal baud rate.
 */
`timescale 1ns/10ps

// Behaviour
// - Completed character moves to an empty receive buffer and sets the full flag.
// - Receive buffer is read-only on the bus, separate from the shifter.
// - Interrupt request whenever full flag and receive interrupt enable are set.
// - Line is sampled at sixteen oversample ticks per bit.
// - Tick count resyncs after start bit and after a 1-to-0 data change.
// - Start search waits for a 0 after three 1s, then counts ticks.
// - Start verified by ticks 3,5,7; at most one 1; single 1 flags noise.
// - Failed start verification clears the tick count and restarts the search.
// - Data bit is majority of ticks 8,9,10; disagreement flags noise.
// - Any 1 at start ticks 8,9,10 flags noise; bit stays a start.
// - Stop majority 0 sets framing error; disagreement flags noise.
// - Framing error is set in the same cycle as the full flag.
// - A break character sets the framing error flag.
// - A falling edge after a decided 1 data bit, outside ticks 8,9,10, resyncs the tick count.
// - Stop sampled at tick 10 of its bit time after the data bits.
// - Control bit selects eight or nine data bits.
// - All-zero data and zero stop set break flag and clear the buffer.
module urdr_rx #(
    parameter int CLK_HZ  = 200_000_000,
    parameter int BAUD_HZ = 9600
) (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Serial input.
    input  wire logic        rx_i,
    // Write address channel.
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [3:0]  s_axi_awaddr_i,
    // Write data channel.
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    // Write response channel.
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    // Read address channel.
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [3:0]  s_axi_araddr_i,
    // Read data channel.
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    // Receiver interrupt request.
    output logic             irq_o
);

    // System clocks per oversample tick.
    localparam int RT_DIV = CLK_HZ / (urdr_pkg::RT_PER_BIT * BAUD_HZ);
    localparam logic [urdr_pkg::DIV_W-1:0] DIV_LAST = urdr_pkg::DIV_W'(RT_DIV - 1);

    // The divider counter must hold the count and the count must not be zero.
    if (RT_DIV < 1 || RT_DIV >= (1 << urdr_pkg::DIV_W)) begin : g_div_check
        $error("Oversample divider out of range for this clock and baud rate.");
    end

    urdr_pkg::urdr_state_t state_reg;
    urdr_pkg::urdr_state_t state_next;

    logic       tick;
    logic [4:0] cur;
    logic [2:0] vote3;
    logic       maj;
    logic       split;
    logic       fall;
    logic       resync;
    logic [3:0] n_bits;
    logic [8:0] char_data;
    logic       rd_data;

    // Outputs are fields of the registered state.
    assign s_axi_awready_o = state_reg.awready;
    assign s_axi_wready_o  = state_reg.wready;
    assign s_axi_bvalid_o  = state_reg.bvalid;
    assign s_axi_bresp_o   = state_reg.bresp;
    assign s_axi_arready_o = state_reg.arready;
    assign s_axi_rvalid_o  = state_reg.rvalid;
    assign s_axi_rdata_o   = state_reg.rdata;
    assign s_axi_rresp_o   = state_reg.rresp;
    assign irq_o           = state_reg.irq;

    // Next-state logic for the bus slave, the control bits and the receiver.
    always_comb begin
        state_next = state_reg;
        tick       = (state_reg.div == '0);
        cur        = state_reg.rt_cnt + 5'h01;
        vote3      = {state_reg.votes[1:0], rx_i};
        maj        = (vote3[2] & vote3[1]) | (vote3[2] & vote3[0]) | (vote3[1] & vote3[0]);
        split      = (vote3 != 3'h0) && (vote3 != 3'h7);
        fall       = state_reg.hist[0] & ~rx_i;
        n_bits     = state_reg.char9 ? urdr_pkg::BITS_LONG : urdr_pkg::BITS_SHORT;
        char_data  = state_reg.char9 ? state_reg.shifter : {1'b0, state_reg.shifter[8:1]};
        rd_data    = 1'b0;
        resync     = 1'b0;

        // Oversample tick divider; free running so ticks stay evenly spaced.
        state_next.div = tick ? DIV_LAST : state_reg.div - 1'b1;

        // Write address and data are taken independently, in either order.
        if (state_reg.awready && s_axi_awvalid_i) begin
            state_next.aw_have = 1'b1;
            state_next.aw_ofs  = s_axi_awaddr_i;
        end
        if (state_reg.wready && s_axi_wvalid_i) begin
            state_next.w_have = 1'b1;
            state_next.wdata  = s_axi_wdata_i;
            state_next.wstrb  = s_axi_wstrb_i;
        end
        if (state_reg.bvalid && s_axi_bready_i) begin
            state_next.bvalid = 1'b0;
        end
        // Both halves present: apply the write and answer it.
        if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = urdr_pkg::RESP_OKAY;
            unique case (state_reg.aw_ofs)
                urdr_pkg::OFS_CONTROL: begin
                    if (state_reg.wstrb[0]) begin
                        state_next.rx_en  = state_reg.wdata[urdr_pkg::CTL_RX_EN];
                        state_next.char9  = state_reg.wdata[urdr_pkg::CTL_CHAR9];
                        state_next.irq_en = state_reg.wdata[urdr_pkg::CTL_IRQ_EN];
                    end
                end
                // Status and buffer ignore writes; the buffer stays read-only.
                urdr_pkg::OFS_STATUS, urdr_pkg::OFS_DATA: begin
                    state_next.bresp = urdr_pkg::RESP_OKAY;
                end
                default: begin
                    state_next.bresp = urdr_pkg::RESP_SLVERR;
                end
            endcase
        end
        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready  = !state_next.w_have && !state_next.bvalid;

        // Reads answer one cycle after the address is taken.
        if (state_reg.rvalid && s_axi_rready_i) begin
            state_next.rvalid = 1'b0;
        end
        if (state_reg.arready && s_axi_arvalid_i) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = urdr_pkg::RESP_OKAY;
            state_next.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr_i)
                urdr_pkg::OFS_CONTROL: begin
                    state_next.rdata[urdr_pkg::CTL_RX_EN]  = state_reg.rx_en;
                    state_next.rdata[urdr_pkg::CTL_CHAR9]  = state_reg.char9;
                    state_next.rdata[urdr_pkg::CTL_IRQ_EN] = state_reg.irq_en;
                end
                urdr_pkg::OFS_STATUS: begin
                    state_next.rdata[urdr_pkg::STAT_FULL]  = state_reg.full;
                    state_next.rdata[urdr_pkg::STAT_NOISE] = state_reg.noise;
                    state_next.rdata[urdr_pkg::STAT_FE]    = state_reg.fe;
                    state_next.rdata[urdr_pkg::STAT_BRK]   = state_reg.brk;
                    state_next.rdata[urdr_pkg::STAT_BUSY]  =
                        (state_reg.phase != urdr_pkg::RX_IDLE);
                end
                urdr_pkg::OFS_DATA: begin
                    state_next.rdata[8:0] = state_reg.rx_buf;
                    rd_data = 1'b1;
                end
                default: begin
                    state_next.rresp = urdr_pkg::RESP_SLVERR;
                end
            endcase
        end
        state_next.arready = !state_next.rvalid;

        // Reading the buffer releases it; a character ending in that cycle still sees the old full flag below.
        if (rd_data) begin
            state_next.full  = 1'b0;
            state_next.noise = 1'b0;
            state_next.fe    = 1'b0;
            state_next.brk   = 1'b0;
        end

        // Receiver, advanced once per oversample tick.
        if (!state_reg.rx_en) begin
            state_next.phase  = urdr_pkg::RX_IDLE;
            state_next.rt_cnt = 5'h00;
            state_next.hist   = 3'h0;
        end else if (tick) begin
            state_next.hist   = {state_reg.hist[1:0], rx_i};
            state_next.rt_cnt = cur;
            if (cur == urdr_pkg::TICK_VOTE_A || cur == urdr_pkg::TICK_VOTE_B ||
                cur == urdr_pkg::TICK_VOTE_C) begin
                state_next.votes = vote3;
            end
            unique case (state_reg.phase)
                urdr_pkg::RX_IDLE: begin
                    state_next.rt_cnt = 5'h00;
                    // A 0 after three 1s is a candidate start edge; it is tick 1.
                    if (state_reg.hist == 3'h7 && !rx_i) begin
                        state_next.phase     = urdr_pkg::RX_START;
                        state_next.rt_cnt    = 5'h01;
                        state_next.votes     = 3'h0;
                        state_next.noise_acc = 1'b0;
                        state_next.last_bit  = 1'b0;
                    end
                end
                urdr_pkg::RX_START: begin
                    if (cur == urdr_pkg::TICK_VERIFY_A || cur == urdr_pkg::TICK_VERIFY_B) begin
                        state_next.votes = vote3;
                    end
                    if (cur == urdr_pkg::TICK_VERIFY_C) begin
                        state_next.votes = 3'h0;
                        // Two or more 1s reject the start bit.
                        if (vote3 == 3'h3 || vote3 == 3'h5 || vote3 == 3'h6 ||
                            vote3 == 3'h7) begin
                            state_next.phase  = urdr_pkg::RX_IDLE;
                            state_next.rt_cnt = 5'h00;
                        end else if (vote3 != 3'h0) begin
                            state_next.noise_acc = 1'b1;
                        end
                    end
                    // Late 1s in the start bit are noise but do not cancel it.
                    if (cur == urdr_pkg::TICK_VOTE_C && vote3 != 3'h0) begin
                        state_next.noise_acc = 1'b1;
                    end
                    if (cur == urdr_pkg::TICK_LAST) begin
                        state_next.phase   = urdr_pkg::RX_DATA;
                        state_next.rt_cnt  = 5'h00;
                        state_next.bit_idx = 4'h0;
                    end
                end
                urdr_pkg::RX_DATA: begin
                    if (cur == urdr_pkg::TICK_VOTE_C) begin
                        state_next.shifter  = {maj, state_reg.shifter[8:1]};
                        state_next.last_bit = maj;
                        if (split) begin
                            state_next.noise_acc = 1'b1;
                        end
                    end
                    // An edge after a decided 1 marks the next bit's tick 1;
                    // the vote window is excluded so a glitch cannot shift it.
                    resync = state_reg.last_bit && fall &&
                             (cur < urdr_pkg::TICK_VOTE_A || cur > urdr_pkg::TICK_VOTE_C);
                    if (resync) begin
                        state_next.rt_cnt   = 5'h01;
                        state_next.last_bit = 1'b0;
                    end
                    // An early edge ends the current bit ahead of tick 16.
                    if (cur == urdr_pkg::TICK_LAST || (resync && cur > urdr_pkg::TICK_VOTE_C)) begin
                        if (!resync) begin
                            state_next.rt_cnt = 5'h00;
                        end
                        if (state_reg.bit_idx == n_bits - 4'h1) begin
                            state_next.phase = urdr_pkg::RX_STOP;
                        end else begin
                            state_next.bit_idx = state_reg.bit_idx + 4'h1;
                        end
                    end
                end
                urdr_pkg::RX_STOP: begin
                    // Stop decided at tick 10 of the bit after the last data bit.
                    if (cur == urdr_pkg::TICK_VOTE_C) begin
                        state_next.phase  = urdr_pkg::RX_IDLE;
                        state_next.rt_cnt = 5'h00;
                        // A full buffer keeps its old character; the new one is lost.
                        if (!state_reg.full) begin
                            state_next.full  = 1'b1;
                            state_next.fe    = !maj;
                            state_next.noise = state_reg.noise_acc | split;
                            state_next.brk   = !maj && (char_data == 9'h000);
                            state_next.rx_buf = char_data;
                            if (!maj && char_data == 9'h000) begin
                                state_next.rx_buf = 9'h000;
                            end
                        end
                    end
                end
            endcase
        end

        // Request follows the flag and the enable in the same cycle.
        state_next.irq = state_next.full & state_next.irq_en;
    end

    // Single state register; reset idles the search and clears history.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= urdr_pkg::STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // urdr_rx

/* File: urdr_pkg.sv */
/*
 * Shared constants and state types for the receive data recovery block:
 * register offsets and field positions, oversample tick positions,
 * bus response codes and the packed state record.
 * Assumes a single 200 MHz clock domain and an AXI4-Lite master.
 */
package urdr_pkg;

    // Oversample ticks per bit time.
    localparam int RT_PER_BIT = 16;

    // Tick positions inside one bit time, counted from 1.
    localparam logic [4:0] TICK_VERIFY_A = 5'h03;
    localparam logic [4:0] TICK_VERIFY_B = 5'h05;
    localparam logic [4:0] TICK_VERIFY_C = 5'h07;
    localparam logic [4:0] TICK_VOTE_A   = 5'h08;
    localparam logic [4:0] TICK_VOTE_B   = 5'h09;
    localparam logic [4:0] TICK_VOTE_C   = 5'h0A;
    localparam logic [4:0] TICK_LAST     = 5'h10;

    // Data bits per character for the two character lengths.
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG  = 4'h9;

    // Register byte offsets.
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_DATA    = 4'h8;

    // Control register fields.
    localparam int CTL_RX_EN  = 0;
    localparam int CTL_CHAR9  = 1;
    localparam int CTL_IRQ_EN = 2;

    // Status register fields.
    localparam int STAT_FULL  = 0;
    localparam int STAT_NOISE = 1;
    localparam int STAT_FE    = 2;
    localparam int STAT_BRK   = 3;
    localparam int STAT_BUSY  = 4;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Widest oversample divider the counter can hold.
    localparam int DIV_W = 12;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } urdr_phase_t;

    typedef struct packed {
        // Bus slave.
        logic              awready;
        logic              aw_have;
        logic [3:0]        aw_ofs;
        logic              wready;
        logic              w_have;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        // Control.
        logic              rx_en;
        logic              char9;
        logic              irq_en;
        // Receiver.
        logic [DIV_W-1:0]  div;
        urdr_phase_t       phase;
        logic [4:0]        rt_cnt;
        logic [2:0]        hist;
        logic [2:0]        votes;
        logic [3:0]        bit_idx;
        logic [8:0]        shifter;
        logic              last_bit;
        logic              noise_acc;
        // Visible results.
        logic [8:0]        rx_buf;
        logic              full;
        logic              noise;
        logic              fe;
        logic              brk;
        logic              irq;
    } urdr_state_t;

    localparam urdr_state_t STATE_RESET = '0;

endpackage

/* File: urdr_rx_properties.sv */
/*
 * Checker for the receive data recovery block: bus answer timing,
 * response codes and interrupt relations.
 * Assumes it is bound to urdr_rx and sees only that module's ports.
 */
`timescale 1ns/10ps
module urdr_rx_checker (
    // Clock, reset and line.
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        rx_i,
    // Bus.
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [3:0]  s_axi_awaddr_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0]  s_axi_wstrb_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [3:0]  s_axi_araddr_i,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    // Interrupt.
    input wire logic        irq_o
);
    logic [3:0] aw_q;
    logic [3:0] ar_q;
    logic       ws_q;
    logic       wd_q;
    logic       ien_q;
    logic       aw_h;
    logic       w_h;
    logic [7:0] ones_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    function automatic logic mapd(input logic [3:0] a);
        return a == 4'h0 || a == 4'h4 || a == 4'h8;
    endfunction

    // Shadows of bus addresses and the enable bit, so answers are judged
    // from the port traffic alone; the idle counter saturates to stay small.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ien_q <= 1'b0;
            aw_h <= 1'b0;
            w_h <= 1'b0;
            ones_q <= 8'h00;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
            if (s_axi_awvalid_i && s_axi_awready_o) aw_h <= 1'b1;
            if (s_axi_wvalid_i && s_axi_wready_o) w_h <= 1'b1;
            if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i;
            if (s_axi_wvalid_i && s_axi_wready_o) ws_q <= s_axi_wstrb_i[0];
            if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i[2];
            // The enable changes the cycle after both halves sit latched, together with the answer.
            if (aw_h && w_h && !s_axi_bvalid_o) begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                if (aw_q == 4'h0 && ws_q) ien_q <= wd_q;
            end
            ones_q <= !rx_i ? 8'h00 : (ones_q == 8'hFF ? ones_q : ones_q + 8'h01);
        end
    end

    property p_write_answer;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer not two cycles after the request");
    property p_bresp_code;
        s_axi_bvalid_o |-> s_axi_bresp_o == (mapd(aw_q) ? urdr_pkg::RESP_OKAY : urdr_pkg::RESP_SLVERR);
    endproperty
    a_bresp_code: assert property (p_bresp_code)
        else $error("write response code wrong");
    property p_read_answer;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
            && s_axi_rresp_o == (mapd(ar_q) ? urdr_pkg::RESP_OKAY : urdr_pkg::RESP_SLVERR);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late or code wrong");
    property p_data_width;
        s_axi_rvalid_o && ar_q == urdr_pkg::OFS_DATA |-> s_axi_rdata_o[31:9] == 23'h000000;
    endproperty
    a_data_width: assert property (p_data_width)
        else $error("data read has bits above the buffer");
    property p_irq_full;
        s_axi_rvalid_o && ar_q == urdr_pkg::OFS_STATUS && $past(irq_o) |-> s_axi_rdata_o[0];
    endproperty
    a_irq_full: assert property (p_irq_full)
        else $error("interrupt without full flag");
    property p_irq_enable;
        $rose(irq_o) |-> ien_q;
    endproperty
    a_irq_enable: assert property (p_irq_enable)
        else $error("interrupt while disabled");
    property p_irq_after_line;
        $rose(irq_o) |-> ones_q < 8'hC8;
    endproperty
    a_irq_after_line: assert property (p_irq_after_line)
        else $error("character completed on an idle line");
    property p_reset_quiet;
        $fell(reset_i) |-> !irq_o && !s_axi_rvalid_o && !s_axi_bvalid_o && !s_axi_awready_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");
endmodule // urdr_rx_checker

bind urdr_rx urdr_rx_checker urdr_rx_checker_i (.*);

/* File: urdr_tx_model.sv */
/*
 * Far-end transmitter: frames LSB first with a chosen bit length and
 * one optional inverted sample. Assumes one oversample tick per clock.
 */
`timescale 1ns/10ps
module urdr_tx_model (
    // Clock.
    input  wire logic sys_clk_i,
    // Serial line, idle high.
    output logic      line_o
);
    initial line_o = 1'b1;

    // Bit gb (0 start, n+1 stop) is inverted at clock gt to inject noise.
    task automatic send(input logic [8:0] d, input int n, input logic stp,
                        input int per, input int gb, input int gt);
        logic v;
        for (int b = 0; b <= n + 1; b++) begin
            v = (b == 0) ? 1'b0 : (b <= n) ? d[b-1] : stp;
            for (int t = 1; t <= per; t++) begin
                @(posedge sys_clk_i);
                line_o <= (b == gb && t == gt) ? ~v : v;
            end
        end
        @(posedge sys_clk_i);
        line_o <= 1'b1;
        repeat (24) @(posedge sys_clk_i);
    endtask

    // A low pulse too short to survive the verify samples.
    task automatic false_start();
        @(posedge sys_clk_i);
        line_o <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        line_o <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
    endtask
endmodule // urdr_tx_model

/* File: testbench.sv */
/*
 * Testbench for the receive data recovery block: bus tasks and frames
 * sent by the far-end model. Assumes one oversample tick per clock.
 */
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [3:0]  awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0;
    logic        rx, awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v;
    int          err_count = 0, n_compared = 0, cycles = 0;

    urdr_rx #(.BAUD_HZ(12_500_000)) urdr_rx_i (
        .sys_clk_i(clk), .reset_i(rst), .rx_i(rx),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_awaddr_i(awa),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wready), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bre),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
        .s_axi_araddr_i(ara), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rre),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .irq_o(irq));
    urdr_tx_model urdr_tx_model_i (.sys_clk_i(clk), .line_o(rx));

    // Half period of 2.5 ns gives 200 MHz.
    always #2.5 clk = ~clk;

    // Watchdog; a full run needs well under this many cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // Address and data go out together; each is released once it is taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) aw_done = 1'b1;
            if (wready === 1'b1) w_done = 1'b1;
            if (aw_done) awv <= 1'b0;
            if (w_done) wv <= 1'b0;
        end while (!(aw_done && w_done));
        do @(posedge clk); while (bvalid !== 1'b1);
        bre <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        rre <= 1'b0;
    endtask

    // Sends one frame, times the interrupt, then reads status and data.
    task automatic frame(input logic [8:0] d, input int n, stp, per, gb, gt,
                         input logic [3:0] st, input int lo, hi);
        int lat;
        fork
            urdr_tx_model_i.send(d, n, stp, per, gb, gt);
            begin
                lat = 0;
                while (irq !== 1'b1 && lat < 300) begin
                    @(posedge clk);
                    lat++;
                end
            end
        join
        chk("latency in range", 32'h1, {31'h0, lat >= lo && lat <= hi});
        rd(urdr_pkg::OFS_STATUS, v);
        chk("status", {28'h0, st}, v & 32'h0000000F);
        rd(urdr_pkg::OFS_DATA, v);
        chk("data", {23'h0, d}, v);
        rd(urdr_pkg::OFS_STATUS, v);
        chk("status after read", 32'h0, v & 32'h0000000F);
        chk("irq after read", 32'h0, {31'h0, irq});
        $display("test done, character %h", d);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd(4'(4 * i), v);
            chk("reset value", 32'h0, v);
        end
        wr(4'hC, 32'h1, urdr_pkg::RESP_SLVERR);
        wr(urdr_pkg::OFS_DATA, 32'h1FF, urdr_pkg::RESP_OKAY);
        wr(urdr_pkg::OFS_CONTROL, 32'h5, urdr_pkg::RESP_OKAY);
        // Enabling starts from a cleared line history; let three idle samples land.
        repeat (4) @(posedge clk);
        $display("test done, reset values and bus errors");
        frame(9'h0A5, 8, 1, 16, -1, 0, 4'h1, 154, 160);
        frame(9'h0A5, 8, 1, 16, 4, 9, 4'h3, 154, 160);
        frame(9'h0C3, 8, 1, 16, 0, 5, 4'h3, 154, 160);
        frame(9'h0C3, 8, 1, 16, 0, 9, 4'h3, 154, 160);
        urdr_tx_model_i.false_start();
        rd(urdr_pkg::OFS_STATUS, v);
        chk("status after false start", 32'h0, v & 32'h0000000F);
        $display("test done, false start");
        frame(9'h03C, 8, 1, 16, -1, 0, 4'h1, 154, 160);
        frame(9'h03C, 8, 1, 16, 9, 9, 4'h3, 154, 160);
        frame(9'h03C, 8, 0, 16, -1, 0, 4'h5, 154, 160);
        frame(9'h000, 8, 0, 16, -1, 0, 4'hD, 154, 160);
        frame(9'h055, 8, 1, 18, -1, 0, 4'h1, 0, 300);
        wr(urdr_pkg::OFS_CONTROL, 32'h7, urdr_pkg::RESP_OKAY);
        frame(9'h1A5, 9, 1, 16, -1, 0, 4'h1, 170, 176);
        wr(urdr_pkg::OFS_CONTROL, 32'h1, urdr_pkg::RESP_OKAY);
        frame(9'h05A, 8, 1, 16, -1, 0, 4'h1, 300, 300);
        results();
    end
endmodule // testbench
